// >>> rtl/dsr_sync_regs.sv
/*
  dsr_sync_regs: multi-chip sync control, sync status and phase
  readback, receiver level status and data-clock strobe delay control,
  all reached over the three-wire serial port. Assumes core_clk stands
  for the conversion clock, and that the sync pin and the analog level
  comparator outputs are asynchronous to it.
*/
`timescale 1ns/1ps
module dsr_sync_regs
  import dsr_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       reset,
  input  wire logic       sclkPin,
  input  wire logic       csPinN,
  input  wire logic       sdioIn,
  output logic            sdioOut,
  output logic            sdioOeN,
  input  wire logic       syncPin,
  input  wire logic [5:0] levelPins,
  output logic            syncEnable,
  output logic            phaseAlignStrobe,
  output logic            syncLocked,
  output logic            strobeDelayBypass,
  output logic [1:0]      strobeDelayCode,
  output logic [9:0]      strobeDelayPs
);

  // serial port side
  logic       wrStrobe;        // one-cycle write pulse
  logic [6:0] regAddr;         // frame address
  logic [7:0] wrData;          // frame write data
  logic [7:0] rdData;          // read mux result

  // software registers
  logic [7:0] syncCtrl_reg;    // enable, rate, edge, averaging
  logic [7:0] phaseReq_reg;    // requested phase offset
  logic [7:0] strobeDly_reg;   // bypass and delay code

  // hardware state
  logic [1:0] syncPipe_reg;    // sync pin meta, sync
  logic       syncPrev_reg;    // previous synchronised sync
  logic [5:0] levelMeta_reg;   // level comparator first stage
  logic [5:0] levelStat_reg;   // level flags as read
  logic [5:0] phaseCnt_reg;    // conversion-clock phase counter
  logic [2:0] rateCnt_reg;     // edges seen at FIFO reset rate
  logic [14:0] accum_reg;      // sum of phase samples
  logic [7:0] sampleCnt_reg;   // samples in current average
  logic [7:0] readback_reg;    // averaged phase, 6.2
  logic       locked_reg;      // sync attained
  logic       lost_reg;        // sync attained then lost

  dsr_spi_slave u_spi (
    .core_clk (core_clk),
    .reset    (reset),
    .sclkPin  (sclkPin),
    .csPinN   (csPinN),
    .sdioIn   (sdioIn),
    .sdioOut  (sdioOut),
    .sdioOeN  (sdioOeN),
    .wrStrobe (wrStrobe),
    .regAddr  (regAddr),
    .wrData   (wrData),
    .rdData   (rdData)
  );

  // control fields
  wire       ctrlEnable = syncCtrl_reg[CTRL_ENABLE_BIT];
  wire       ctrlRate   = syncCtrl_reg[CTRL_RATE_BIT];
  wire       ctrlRise   = syncCtrl_reg[CTRL_EDGE_BIT];
  wire [2:0] ctrlAvg    = syncCtrl_reg[CTRL_AVG_MSB:0];
  wire [5:0] reqPhase   = phaseReq_reg[5:0];

  // write decode: only the read/write registers take writes
  wire wrCtrl  = wrStrobe && (regAddr == ADDR_SYNC_CTRL);
  wire wrReq   = wrStrobe && (regAddr == ADDR_PHASE_REQ);
  wire wrDly   = wrStrobe && (regAddr == ADDR_STROBE_DLY);

  // sync edge detection on synchronised samples
  wire syncNow  = syncPipe_reg[1];
  wire riseSeen = syncNow & ~syncPrev_reg;
  wire fallSeen = ~syncNow & syncPrev_reg;
  wire edgeSeen = ctrlRise ? riseSeen : fallSeen;
  wire trigEdge = ctrlEnable & edgeSeen;

  // data rate: every edge; FIFO reset rate: every eighth edge
  wire rateHit    = ctrlRate || (rateCnt_reg == FIFO_RATE_LAST);
  wire sampleTake = trigEdge & rateHit;

  // phase sample in 6.2, whole cycles only
  wire [7:0]  phaseSample = {phaseCnt_reg, 2'b00};
  wire [14:0] accumSum    = accum_reg + {7'h00, phaseSample};
  wire [7:0]  avgTarget   = 8'h01 << ctrlAvg;
  wire        avgDone     = sampleTake &&
                            (sampleCnt_reg == avgTarget - 8'h01);
  wire [14:0] avgShift    = accumSum >> ctrlAvg;
  wire [7:0]  avgValue    = avgShift[7:0];
  wire        avgMatch    = (avgValue == {reqPhase, 2'b00});

  // lock bookkeeping; clearing enable clears both lock and loss
  wire lockNext = ctrlEnable && (avgDone ? avgMatch : locked_reg);
  wire lostSet  = avgDone && locked_reg && !avgMatch;
  wire lostNext = lostSet || (ctrlEnable && lost_reg);

  // strobe delay decode
  wire [1:0] dlyCode = strobeDly_reg[DLY_CODE_MSB:0];
  wire [9:0] dlyPs   = (dlyCode == 2'h0) ? DLY_CODE0_PS :
                       (dlyCode == 2'h1) ? DLY_CODE1_PS :
                       (dlyCode == 2'h2) ? DLY_CODE2_PS :
                                           DLY_CODE3_PS;

  // read mux; reads have no side effect
  wire [7:0] statByte = {lost_reg, locked_reg, 6'h00};
  assign rdData =
    (regAddr == ADDR_SYNC_CTRL)  ? syncCtrl_reg :
    (regAddr == ADDR_PHASE_REQ)  ? phaseReq_reg :
    (regAddr == ADDR_SYNC_STAT)  ? statByte :
    (regAddr == ADDR_PHASE_RDBK) ? readback_reg :
    (regAddr == ADDR_LEVEL_STAT) ? {2'b00, levelStat_reg} :
    (regAddr == ADDR_STROBE_DLY) ? strobeDly_reg :
                                   8'h00;

  // software registers
  always_ff @(posedge core_clk) begin
    if (reset) begin
      syncCtrl_reg  <= SYNC_CTRL_RST;
      phaseReq_reg  <= PHASE_REQ_RST;
      strobeDly_reg <= STROBE_DLY_RST;
    end else begin
      if (wrCtrl) syncCtrl_reg <= wrData & 8'hCF;           // bits 5:4 zero
      if (wrReq)  phaseReq_reg <= {2'b00, wrData[5:0]};
      if (wrDly)  strobeDly_reg <= {5'h00, wrData[2:0]};
    end
  end

  // pin synchronisers
  always_ff @(posedge core_clk) begin
    if (reset) begin
      syncPipe_reg  <= 2'h0;
      syncPrev_reg  <= 1'b0;
      levelMeta_reg <= 6'h00;
      levelStat_reg <= 6'h00;
    end else begin
      syncPipe_reg  <= {syncPipe_reg[0], syncPin};
      syncPrev_reg  <= syncPipe_reg[1];
      levelMeta_reg <= levelPins;
      levelStat_reg <= levelMeta_reg;
    end
  end

  // free-running phase counter, one step per conversion cycle
  always_ff @(posedge core_clk) begin
    if (reset) phaseCnt_reg <= 6'h00;
    else       phaseCnt_reg <= phaseCnt_reg + 6'h01;
  end

  // rate divider and averaging accumulator
  always_ff @(posedge core_clk) begin
    if (reset || !ctrlEnable) begin
      rateCnt_reg   <= 3'h0;
      accum_reg     <= 15'h0000;
      sampleCnt_reg <= 8'h00;
    end else begin
      if (trigEdge) rateCnt_reg <= rateCnt_reg + 3'h1;
      if (avgDone) begin
        accum_reg     <= 15'h0000;
        sampleCnt_reg <= 8'h00;
      end else if (sampleTake) begin
        accum_reg     <= accumSum;
        sampleCnt_reg <= sampleCnt_reg + 8'h01;
      end
    end
  end

  // readback and lock flags
  always_ff @(posedge core_clk) begin
    if (reset) begin
      readback_reg <= 8'h00;
      locked_reg   <= 1'b0;
      lost_reg     <= 1'b0;
    end else begin
      if (avgDone) readback_reg <= avgValue;
      locked_reg <= lockNext;
      lost_reg   <= lostNext;
    end
  end

  // outputs, all from flops
  always_ff @(posedge core_clk) begin
    if (reset) begin
      syncEnable        <= 1'b0;
      phaseAlignStrobe  <= 1'b0;
      syncLocked        <= 1'b0;
      strobeDelayBypass <= 1'b0;
      strobeDelayCode   <= 2'h0;
      strobeDelayPs     <= 10'h000;
    end else begin
      syncEnable        <= ctrlEnable;
      // marks the requested output phase while locked
      phaseAlignStrobe  <= locked_reg && (phaseCnt_reg == reqPhase);
      syncLocked        <= locked_reg;
      strobeDelayBypass <= strobeDly_reg[DLY_BYPASS_BIT];
      strobeDelayCode   <= dlyCode;
      // bypass removes the applied delay
      strobeDelayPs     <= strobeDly_reg[DLY_BYPASS_BIT] ?
                           10'h000 : dlyPs;
    end
  end

  // checks next to the logic they guard
  // no lock, loss or edge count survives a disable
  AST_SYNC_OFF: assert property (
    @(posedge core_clk) disable iff (reset)
    !ctrlEnable |-> !sampleTake ##1
      (!locked_reg && !lost_reg && rateCnt_reg == 3'h0))
    else $error("lock or sample while sync disabled");

  // a control write lands with the reserved bits cleared
  AST_CTRL_WR: assert property (
    @(posedge core_clk) disable iff (reset)
    wrCtrl |=> syncCtrl_reg == ($past(wrData) & 8'hCF))
    else $error("control write not stored");

  // enable output follows the control bit one cycle on
  AST_EN_OUT: assert property (
    @(posedge core_clk) disable iff (reset)
    syncEnable == $past(ctrlEnable))
    else $error("enable output out of step");

  // fifo reset rate takes only the eighth edge
  AST_FIFO_RATE: assert property (
    @(posedge core_clk) disable iff (reset)
    sampleTake && !ctrlRate |-> rateCnt_reg == 3'h7)
    else $error("fifo-rate sample on wrong edge");

  // data rate takes every qualified edge
  AST_DATA_RATE: assert property (
    @(posedge core_clk) disable iff (reset)
    trigEdge && ctrlRate |-> sampleTake)
    else $error("data-rate edge not sampled");

  // sample only on the selected polarity
  AST_EDGE_SEL: assert property (
    @(posedge core_clk) disable iff (reset)
    sampleTake |-> syncNow == ctrlRise && $past(syncNow) != ctrlRise)
    else $error("sync taken on wrong edge");

  // readback only moves when an average completes
  AST_AVG_HOLD: assert property (
    @(posedge core_clk) disable iff (reset)
    !avgDone |=> $stable(readback_reg))
    else $error("readback moved without finished average");

  // a finished average restarts the sum and the count
  AST_AVG_CLR: assert property (
    @(posedge core_clk) disable iff (reset)
    avgDone |=> sampleCnt_reg == 8'h00 && accum_reg == 15'h0000)
    else $error("average not restarted");

  // phase strobe lands on the requested phase
  AST_PHASE_OUT: assert property (
    @(posedge core_clk) disable iff (reset)
    phaseAlignStrobe |-> $past(phaseCnt_reg) == $past(reqPhase))
    else $error("phase strobe at wrong phase");

  // request write keeps six bits, top two read zero
  AST_REQ_WR: assert property (
    @(posedge core_clk) disable iff (reset)
    wrReq |=> phaseReq_reg == {2'b00, $past(wrData[5:0])})
    else $error("phase request write not stored");

  // loss only follows a held lock
  AST_LOST_SET: assert property (
    @(posedge core_clk) disable iff (reset)
    $rose(lost_reg) |-> $past(locked_reg) && !locked_reg)
    else $error("lost set without prior lock");

  // loss stays put while sync remains enabled
  AST_LOST_HOLD: assert property (
    @(posedge core_clk) disable iff (reset)
    lost_reg && ctrlEnable |=> lost_reg)
    else $error("lost flag dropped while enabled");

  // lock rises only on a matching average
  AST_LOCK_SET: assert property (
    @(posedge core_clk) disable iff (reset)
    $rose(locked_reg) |-> readback_reg == {$past(reqPhase), 2'b00})
    else $error("lock without matching readback");

  // a mismatching average drops the lock
  AST_LOCK_DROP: assert property (
    @(posedge core_clk) disable iff (reset)
    avgDone && !avgMatch |=> !locked_reg)
    else $error("lock kept after mismatch");

  // lock output follows the flag one cycle on
  AST_LOCK_OUT: assert property (
    @(posedge core_clk) disable iff (reset)
    syncLocked == $past(locked_reg))
    else $error("lock output out of step");

  // one-sample average is the sample itself
  AST_RDBK_FMT: assert property (
    @(posedge core_clk) disable iff (reset)
    avgDone && ctrlAvg == 3'h0 |=> readback_reg == $past(phaseSample))
    else $error("single-sample readback wrong");

  // level flags trail the pins by the synchroniser
  AST_LEVEL: assert property (
    @(posedge core_clk) disable iff (reset)
    ##2 levelStat_reg == $past(levelPins, 2))
    else $error("level flags do not follow pins");

  // level byte on the read path, top bits zero
  AST_LEVEL_MAP: assert property (
    @(posedge core_clk) disable iff (reset)
    regAddr == ADDR_LEVEL_STAT |-> rdData == {2'b00, levelStat_reg})
    else $error("level byte read wrong");

  // bypass removes any applied delay
  AST_BYPASS: assert property (
    @(posedge core_clk) disable iff (reset)
    strobeDelayBypass |-> strobeDelayPs == 10'h000)
    else $error("delay applied while bypassed");

  // code one gives its own delay
  AST_DLY_PS: assert property (
    @(posedge core_clk) disable iff (reset)
    $past(strobeDly_reg) == 8'h01 |-> strobeDelayPs == 10'd375)
    else $error("delay code 1 not 375 ps");

  // delay code output follows the register
  AST_DLY_CODE: assert property (
    @(posedge core_clk) disable iff (reset)
    strobeDelayCode == $past(strobeDly_reg[DLY_CODE_MSB:0]))
    else $error("delay code output out of step");

  // loss flag untouched by bus traffic while enabled
  AST_RO: assert property (
    @(posedge core_clk) disable iff (reset)
    ctrlEnable && !avgDone |=> $stable(lost_reg) || !$past(ctrlEnable))
    else $error("status flag changed by access");

  // writes to status places leave the three software registers alone
  AST_WR_RO: assert property (
    @(posedge core_clk) disable iff (reset)
    wrStrobe && (regAddr == ADDR_SYNC_STAT || regAddr == ADDR_PHASE_RDBK)
    |=> $stable(syncCtrl_reg) && $stable(phaseReq_reg)
      && $stable(strobeDly_reg))
    else $error("write to status place changed a register");

endmodule : dsr_sync_regs

// >>> rtl/dsr_pkg.sv
/*
  dsr_pkg: register map, field positions, reset values and timing
  constants shared by the sync/receiver status register slice and its
  serial port. Assumes every importer works in the core_clk domain.
*/
// Summary of operation
// - sync logic runs only while enable set
// - rate bit picks FIFO-reset or data rate
// - edge bit picks falling or rising sync
// - averaging code n averages 2^n samples
// - phase request offsets output 0..63 cycles
// - lost flag set when lock later lost
// - locked flag set once sync attained
// - readback is averaged phase, 6.2 format
// - frame line high and low level flags
// - data-clock line high and low flags
// - data line high and low level flags
// - delay bypass bit, zero applies delay
// - delay code picks 165..720 ps shift
package dsr_pkg;

  // register addresses on the serial port
  localparam logic [6:0] ADDR_SYNC_CTRL   = 7'h10;
  localparam logic [6:0] ADDR_PHASE_REQ   = 7'h11;
  localparam logic [6:0] ADDR_SYNC_STAT   = 7'h12;
  localparam logic [6:0] ADDR_PHASE_RDBK  = 7'h13;
  localparam logic [6:0] ADDR_LEVEL_STAT  = 7'h15;
  localparam logic [6:0] ADDR_STROBE_DLY  = 7'h16;

  // sync control fields
  localparam int unsigned CTRL_ENABLE_BIT = 7;
  localparam int unsigned CTRL_RATE_BIT   = 6;
  localparam int unsigned CTRL_EDGE_BIT   = 3;
  localparam int unsigned CTRL_AVG_MSB    = 2;
  // sync status fields
  localparam int unsigned STAT_LOST_BIT   = 7;
  localparam int unsigned STAT_LOCK_BIT   = 6;
  // strobe delay fields
  localparam int unsigned DLY_BYPASS_BIT  = 2;
  localparam int unsigned DLY_CODE_MSB    = 1;

  // reset values
  localparam logic [7:0] SYNC_CTRL_RST    = 8'h48;
  localparam logic [7:0] PHASE_REQ_RST    = 8'h00;
  localparam logic [7:0] STROBE_DLY_RST   = 8'h00;

  // strobe delay per code, picoseconds
  localparam logic [9:0] DLY_CODE0_PS     = 10'd165;
  localparam logic [9:0] DLY_CODE1_PS     = 10'd375;
  localparam logic [9:0] DLY_CODE2_PS     = 10'd615;
  localparam logic [9:0] DLY_CODE3_PS     = 10'd720;

  // sync edges per sample at the FIFO reset rate, minus one
  localparam logic [2:0] FIFO_RATE_LAST   = 3'h7;

  // serial frame: 1 r/w bit, 7 address bits, 8 data bits
  localparam logic [4:0] SPI_ADDR_LAST    = 5'h07;
  localparam logic [4:0] SPI_LAST_BIT     = 5'h0F;

endpackage : dsr_pkg

// >>> rtl/dsr_spi_slave.sv
/*
  dsr_spi_slave: three-wire serial port slave. Frame is MSB first:
  read/write bit (1 = read), 7 address bits, 8 data bits. Assumes the
  serial clock is far slower than core_clk and idles low with chip
  select high between frames.
*/
`timescale 1ns/1ps
module dsr_spi_slave
  import dsr_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       reset,
  input  wire logic       sclkPin,
  input  wire logic       csPinN,
  input  wire logic       sdioIn,
  output logic            sdioOut,
  output logic            sdioOeN,
  output logic            wrStrobe,
  output logic [6:0]      regAddr,
  output logic [7:0]      wrData,
  input  wire logic [7:0] rdData
);

  logic [2:0] sclkPipe_reg;   // meta, sync, previous
  logic [1:0] csPipe_reg;     // meta, sync
  logic [1:0] sdPipe_reg;     // meta, sync
  logic [4:0] bitCnt_reg;     // bits taken in this frame
  logic [7:0] shiftIn_reg;    // incoming bits
  logic       isRead_reg;     // frame is a read

  // edges judged on synchronised samples only
  wire sclkRise = sclkPipe_reg[1] & ~sclkPipe_reg[2];
  wire sclkFall = ~sclkPipe_reg[1] & sclkPipe_reg[2];
  wire inFrame  = ~csPipe_reg[1];
  wire dataPh   = bitCnt_reg[3];
  wire bitIn    = sdPipe_reg[1];

  // pin synchronisers
  always_ff @(posedge core_clk) begin
    if (reset) begin
      sclkPipe_reg <= 3'h0;
      csPipe_reg   <= 2'h3;
      sdPipe_reg   <= 2'h0;
    end else begin
      sclkPipe_reg <= {sclkPipe_reg[1:0], sclkPin};
      csPipe_reg   <= {csPipe_reg[0], csPinN};
      sdPipe_reg   <= {sdPipe_reg[0], sdioIn};
    end
  end

  // frame decoder and read driver
  always_ff @(posedge core_clk) begin
    if (reset || !inFrame) begin
      bitCnt_reg  <= 5'h00;
      shiftIn_reg <= 8'h00;
      isRead_reg  <= 1'b0;
      sdioOut     <= 1'b0;
      sdioOeN     <= 1'b1;
      wrStrobe    <= 1'b0;
      if (reset) begin
        regAddr <= 7'h00;
        wrData  <= 8'h00;
      end
    end else begin
      wrStrobe <= 1'b0;
      if (sclkRise) begin
        // sample on rising edge
        shiftIn_reg <= {shiftIn_reg[6:0], bitIn};
        bitCnt_reg  <= bitCnt_reg + 5'h01;
        if (bitCnt_reg == SPI_ADDR_LAST) begin
          regAddr    <= {shiftIn_reg[5:0], bitIn};
          isRead_reg <= shiftIn_reg[6];
        end
        if (bitCnt_reg == SPI_LAST_BIT && !isRead_reg) begin
          wrData   <= {shiftIn_reg[6:0], bitIn};
          wrStrobe <= 1'b1;
        end
      end else if (sclkFall && isRead_reg && dataPh) begin
        // drive read data on falling edge, MSB first
        sdioOut <= rdData[~bitCnt_reg[2:0]];
        sdioOeN <= 1'b0;
      end
    end
  end

endmodule : dsr_spi_slave

// >>> tb/dsr_sync_source.sv
/*
  dsr_sync_source: external sync pulse source standing beside the
  register slice. Assumes the bench stalls it through hold to move
  the pulse phase against the device's free-running phase counter.
*/
`timescale 1ns/1ps
module dsr_sync_source (
  input  wire logic core_clk,
  input  wire logic hold,
  output logic      syncPin
);
  // position inside a 128-cycle period, a multiple of 64
  logic [6:0] phaseReg = 7'h00;

  // count unless held; each held cycle delays every later edge
  always_ff @(posedge core_clk) begin
    if (!hold) begin
      phaseReg <= phaseReg + 7'h01;
    end
  end

  // high for 32 cycles: falling edge lags rising edge by 32
  assign syncPin = (phaseReg[6:5] == 2'b00);
endmodule : dsr_sync_source

// >>> tb/tb_dsr_sync_regs.sv
/*
  tb_dsr_sync_regs: self-checking bench for the sync and receiver
  status slice. Assumes a 50 MHz core_clk, serial clock of 160 ns and
  the sync source model for the far side.
*/
`timescale 1ns/1ps
module tb_dsr_sync_regs;
  import dsr_pkg::*;
  logic       core_clk = 0, reset = 1, sclkPin = 0, csPinN = 1;
  logic       tbBit = 0, syncHold = 0, sdioIn;
  logic [5:0] levelPins = 6'h00;
  logic       sdioOut, sdioOeN, syncPin, syncEnable, phaseAlignStrobe;
  logic       syncLocked, strobeDelayBypass;
  logic [1:0] strobeDelayCode;
  logic [9:0] strobeDelayPs;
  logic [7:0] q, rb;
  int         bad_count = 0, n_tests = 0;

  // shared sdio line: device drives while its enable is low
  assign sdioIn = sdioOeN ? tbBit : sdioOut;
  always #10 core_clk = ~core_clk;

  dsr_sync_regs dut (.core_clk(core_clk), .reset(reset),
    .sclkPin(sclkPin), .csPinN(csPinN), .sdioIn(sdioIn),
    .sdioOut(sdioOut), .sdioOeN(sdioOeN), .syncPin(syncPin),
    .levelPins(levelPins), .syncEnable(syncEnable),
    .phaseAlignStrobe(phaseAlignStrobe), .syncLocked(syncLocked),
    .strobeDelayBypass(strobeDelayBypass),
    .strobeDelayCode(strobeDelayCode), .strobeDelayPs(strobeDelayPs));
  dsr_sync_source src (.core_clk(core_clk), .hold(syncHold),
    .syncPin(syncPin));

  // compare and count
  task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask : cyc

  // one whole 16-bit frame; released line wanders during read data
  task automatic spi(input logic rd, input logic [6:0] a,
                     input logic [7:0] wd, output logic [7:0] d);
    logic [15:0] f;
    f = {rd, a, wd};
    d = 8'h00;
    csPinN = 1'b0;
    cyc(4);
    for (int i = 15; i >= 0; i--) begin
      sclkPin = 1'b0;
      tbBit = (rd && i < 8) ? ~tbBit : f[i];
      cyc(4);
      sclkPin = 1'b1;
      cyc(2);
      if (rd && i < 8) d[i] = sdioIn;
      cyc(2);
    end
    sclkPin = 1'b0;
    cyc(4);
    csPinN = 1'b1;
    cyc(8);
  endtask : spi

  task automatic wr(input logic [6:0] a, input logic [7:0] wd);
    logic [7:0] d;
    spi(1'b0, a, wd, d);
  endtask : wr

  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    spi(1'b1, a, 8'h00, d);
  endtask : rd

  // reset values of the writable registers
  task automatic t_reset;
    chk(syncEnable, 0);
    rd(ADDR_SYNC_CTRL, q);
    chk(q[7], 0);
    chk(q[6], 1);
    chk(q[3], 1);
    chk(q[2:0], 0);
    rd(ADDR_PHASE_REQ, q);
    chk(q, 8'h00);
    rd(ADDR_STROBE_DLY, q);
    chk(q, 8'h00);
  endtask : t_reset

  // every delay code, then bypass
  task automatic t_delay;
    logic [9:0] ps [4];
    ps = '{10'd165, 10'd375, 10'd615, 10'd720};
    for (int c = 0; c < 4; c++) begin
      wr(ADDR_STROBE_DLY, 8'(c));
      chk(strobeDelayCode, 10'(c));
      chk(strobeDelayPs, ps[c]);
      chk(strobeDelayBypass, 0);
    end
    wr(ADDR_STROBE_DLY, 8'h07);
    chk(strobeDelayBypass, 1);
    chk(strobeDelayPs, 0);
    rd(ADDR_STROBE_DLY, q);
    chk(q, 8'h07);
  endtask : t_delay

  // writes to status places ignored, unmapped read is zero
  task automatic t_readonly;
    wr(ADDR_SYNC_STAT, 8'hFF);
    wr(ADDR_PHASE_RDBK, 8'hFF);
    rd(ADDR_SYNC_STAT, q);
    chk(q, 8'h00);
    rd(ADDR_PHASE_RDBK, q);
    chk(q, 8'h00);
    rd(7'h14, q);
    chk(q, 8'h00);
  endtask : t_readonly

  // each comparator level lands on its own status bit
  task automatic t_level;
    for (int k = 0; k < 6; k++) begin
      levelPins = 6'(1 << k);
      cyc(4);
      rd(ADDR_LEVEL_STAT, q);
      chk(q, 10'(1 << k));
    end
    levelPins = 6'h00;
  endtask : t_level

  // lock, edge choice, phase strobe, loss and disable
  task automatic t_sync;
    int n;
    wr(ADDR_SYNC_CTRL, 8'hC8);
    cyc(400);
    rd(ADDR_PHASE_RDBK, rb);
    chk(rb[1:0], 0);
    wr(ADDR_PHASE_REQ, {2'b00, rb[7:2]});
    cyc(400);
    rd(ADDR_SYNC_STAT, q);
    chk(q, 8'h40);
    chk(syncLocked, 1);
    rd(ADDR_PHASE_RDBK, q);
    chk(q, {rb[7:2], 2'b00});
    n = 0;
    repeat (128) begin
      @(negedge core_clk);
      n += int'(phaseAlignStrobe);
    end
    chk(10'(n), 2);
    wr(ADDR_SYNC_CTRL, 8'h48);
    wr(ADDR_SYNC_CTRL, 8'hC0);
    cyc(400);
    rd(ADDR_PHASE_RDBK, q);
    chk(q, 8'(rb + 8'h80));
    wr(ADDR_SYNC_CTRL, 8'h48);
    wr(ADDR_SYNC_CTRL, 8'hC8);
    cyc(400);
    syncHold = 1'b1;
    cyc(10);
    syncHold = 1'b0;
    cyc(400);
    rd(ADDR_SYNC_STAT, q);
    chk(q, 8'h80);
    chk(syncLocked, 0);
    rd(ADDR_PHASE_RDBK, q);
    chk(q, 8'(rb + 8'd40));
    wr(ADDR_SYNC_CTRL, 8'h48);
    chk(syncEnable, 0);
    rd(ADDR_SYNC_STAT, q);
    chk(q, 8'h00);
  endtask : t_sync

  // FIFO rate takes only every 8th edge
  task automatic t_fifo;
    wr(ADDR_SYNC_CTRL, 8'hC8);
    cyc(400);
    rd(ADDR_PHASE_RDBK, rb);
    wr(ADDR_PHASE_REQ, {2'b00, rb[7:2]});
    wr(ADDR_SYNC_CTRL, 8'h48);
    wr(ADDR_SYNC_CTRL, 8'h88);
    chk(syncEnable, 1);
    cyc(500);
    rd(ADDR_SYNC_STAT, q);
    chk(q, 8'h00);
    cyc(1200);
    rd(ADDR_SYNC_STAT, q);
    chk(q, 8'h40);
  endtask : t_fifo

  // two-sample average of phases four cycles apart
  task automatic t_avg;
    wr(ADDR_SYNC_CTRL, 8'h48);
    @(posedge syncPin);
    cyc(20);
    wr(ADDR_SYNC_CTRL, 8'hC9);
    @(posedge syncPin);
    cyc(10);
    syncHold = 1'b1;
    cyc(4);
    syncHold = 1'b0;
    @(posedge syncPin);
    cyc(8);
    rd(ADDR_PHASE_RDBK, q);
    chk(q, 8'(rb + 8'h08));
    cyc(300);
    rd(ADDR_PHASE_RDBK, q);
    chk(q, 8'(rb + 8'h10));
  endtask : t_avg

  task automatic close_out;
    $display("mismatches %0d of %0d checks", bad_count, n_tests);
    if (bad_count == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : close_out

  // watchdog: tests need about 12000 cycles
  initial begin
    #1000000;
    bad_count++;
    close_out();
  end

  // main sequence
  initial begin
    cyc(4);
    reset = 1'b0;
    cyc(2);
    t_reset();
    t_delay();
    t_readonly();
    t_level();
    t_sync();
    t_fifo();
    t_avg();
    close_out();
  end
endmodule : tb_dsr_sync_regs
